// >>> dv/mcr_misc_control_bench.sv
/*
 * Self-checking bench for the miscellaneous control register block.
 * Assumes mcr_params.svh and mcr_pkg are compiled first; drives all pins.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mcr_params.svh"

module mcr_misc_control_bench
   import mcr_pkg::*;
;
   localparam int TIMEOUT_CYC = 1000;
   typedef struct {int cyc; logic [30:0] vec;} mcr_note_t;
   mcr_note_t   notes[$];
   logic        clk_i = 1'b0, reset_n_i = 1'b0, reg_wr_i = 1'b0;
   logic [7:0]  reg_wdata_i = 8'h00, m_reg = `MCR_MISC_CONTROL_RESET;
   logic        cfg = 1'b1, hp = 1'b1, oe = 1'b1, rate = 1'b0, ratio = 1'b0;
   logic        m_rx = 1'b1, m_ada = 1'b1;
   logic [15:0] stg = 16'h0000, m_lane = 16'h0000, lfsr = 16'h7E78;
   logic [2:0]  phase_tab [4] = '{3'h7, 3'h3, 3'h6, 3'h5};
   int          cyc = 0, fails = 0, check_count = 0;
   wire logic [7:0]  reg_rdata_o;
   wire logic [15:0] lane;
   wire logic [6:0]  flags;
   wire logic [30:0] seen = {reg_rdata_o, lane, flags};

   mcr_misc_control DUT
   (
      .clk_i                  (clk_i),
      .reset_n_i              (reset_n_i),
      .reg_wr_i               (reg_wr_i),
      .reg_wdata_i            (reg_wdata_i),
      .reg_rdata_o            (reg_rdata_o),
      .host_cfg_sel_i         (cfg),
      .sink_hotplug_in_i      (hp),
      .output_enable_i        (oe),
      .rate_above_crossover_i (rate),
      .clock_ratio_flag_i     (ratio),
      .staged_slew_i          (stg[15:14]),
      .staged_term_i          (stg[13:12]),
      .staged_deemph_i        (stg[11:10]),
      .staged_swing_i         (stg[9:4]),
      .staged_eq_level_i      (stg[3:0]),
      .lane_slew_o            (lane[15:14]),
      .lane_term_o            (lane[13:12]),
      .lane_deemph_o          (lane[11:10]),
      .lane_swing_o           (lane[9:4]),
      .lane_eq_level_o        (lane[3:0]),
      .rx_equalizer_on_o      (flags[6]),
      .adaptive_eq_select_o   (flags[5]),
      .eq_center_high_o       (flags[4]),
      .aux_bridge_on_o        (flags[3]),
      .source_hotplug_out_o   (flags[2]),
      .power_down_on_o        (flags[1]),
      .retimer_on_o           (flags[0])
   );

   initial
   begin
      forever #12.5 clk_i = ~clk_i;
   end

   function automatic logic [15:0] lfsr_next(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction

   // Expected outputs from the model state
   function automatic logic [30:0] exp_vec();
      logic ret;
      case (mcr_lane_mode_t'(m_reg[1:0]))
         MCR_MODE_REDRIVER:       ret = 1'b0;
         MCR_MODE_AUTO_CROSSOVER: ret = rate;
         MCR_MODE_AUTO_HIRATE:    ret = rate | ratio;
         default:                 ret = 1'b1;
      endcase
      return {m_reg, m_lane, m_rx, m_ada, m_reg[7], m_reg[3], hp & ~m_reg[6], ~(hp & oe), ret};
   endfunction

   task automatic compare(input logic [30:0] got, input logic [30:0] exp);
      check_count++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] %0t outputs %h expected %h", $time, got, exp);
      end
   endtask

   task automatic note(input int dly);
      notes.push_back('{cyc + dly, exp_vec()});
   endtask

   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Applied lane copy on commit or during power down
   task automatic apply_lanes();
      m_lane = stg;
      m_rx = m_reg[4];
      m_ada = m_reg[5];
   endtask

   task automatic wr(input logic [1:0] mode);
      logic [7:0] b;
      @(posedge clk_i);
      lfsr = lfsr_next(lfsr);
      b = {lfsr[7:2], mode};
      lfsr = lfsr_next(lfsr);
      reg_wr_i <= 1'b1;
      reg_wdata_i <= b;
      stg <= lfsr;
      rate <= lfsr[15] ^ lfsr[0];
      ratio <= lfsr[8] ^ lfsr[1];
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
      m_reg = {b[7:6], cfg ? b[5] : m_reg[5], b[4:3], 1'b0, b[1:0]};
      if (b[2] || !(hp && oe))
         apply_lanes();
      note(3);
      repeat (3) @(posedge clk_i);
   endtask

   task automatic pins(input logic [2:0] p);
      @(posedge clk_i);
      {cfg, hp, oe} <= p;
      repeat (8) @(posedge clk_i);
      if (!(p[1] && p[0]))
         apply_lanes();
      note(1);
   endtask

   // Result watcher
   always @(negedge clk_i)
   begin
      while (notes.size() > 0 && notes[0].cyc <= cyc)
      begin
         compare(seen, notes[0].vec);
         void'(notes.pop_front());
      end
   end

   always @(posedge clk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == TIMEOUT_CYC)
      begin
         fails++;
         complete_run();
      end
   end

   initial
   begin
      repeat (16) @(posedge clk_i);
      notes.push_back('{cyc + 1, {`MCR_MISC_CONTROL_RESET, 16'h0000, 7'h6A}});
      reset_n_i <= 1'b1;
      for (int ph = 0; ph < 4; ph++)
      begin
         pins(phase_tab[ph]);
         for (int i = 0; i < 8; i++)
            wr(i[1:0]);
      end
      repeat (4) @(posedge clk_i);
      complete_run();
   end
endmodule

`default_nettype wire

// >>> rtl/mcr_misc_control.sv
/*
 * Miscellaneous control register of a video-link retimer, with staged
 * lane settings, hot-plug gating and lane function selection.
 * Assumes the host-bus engine delivers whole-byte writes as a one-cycle
 * strobe and samples the read data continuously; pins are asynchronous.
 */
// What this block does
// - Bit 7 picks source or sink centering
// - Bit 6 blocks sink hot-plug forwarding
// - Bit 5 picks fixed or adaptive equalization
// - Adaptive select writes dropped when config pin low
// - Bit 4 enables the receive equalizer
// - Bit 3 enables the auxiliary bridge
// - Writing bit 2 commits staged lane settings
// - Lane settings stay staged until commit or power down
// - Mode 00 is redriver over full range
// - Mode 01 crosses over at 1 Gbps
// - Mode 10 is automatic retimer, high-rate link
// - Mode 11 is retimer over full range
`timescale 1ns/1ps
`default_nettype none
`include "mcr_params.svh"

module mcr_misc_control
   import mcr_pkg::*;
#(
   parameter int SWING_W    = `MCR_SWING_W,
   parameter int EQ_LEVEL_W = `MCR_EQ_LEVEL_W
)
(
   input  wire logic                    clk_i,
   input  wire logic                    reset_n_i,
   input  wire logic                    reg_wr_i,
   input  wire logic [7:0]              reg_wdata_i,
   output var  logic [7:0]              reg_rdata_o,
   input  wire logic                    host_cfg_sel_i,
   input  wire logic                    sink_hotplug_in_i,
   input  wire logic                    output_enable_i,
   input  wire logic                    rate_above_crossover_i,
   input  wire logic                    clock_ratio_flag_i,
   input  wire logic [`MCR_SLEW_W-1:0]   staged_slew_i,
   input  wire logic [`MCR_TERM_W-1:0]   staged_term_i,
   input  wire logic [`MCR_DEEMPH_W-1:0] staged_deemph_i,
   input  wire logic [SWING_W-1:0]      staged_swing_i,
   input  wire logic [EQ_LEVEL_W-1:0]   staged_eq_level_i,
   output var  logic [`MCR_SLEW_W-1:0]   lane_slew_o,
   output var  logic [`MCR_TERM_W-1:0]   lane_term_o,
   output var  logic [`MCR_DEEMPH_W-1:0] lane_deemph_o,
   output var  logic [SWING_W-1:0]      lane_swing_o,
   output var  logic [EQ_LEVEL_W-1:0]   lane_eq_level_o,
   output var  logic                    rx_equalizer_on_o,
   output var  logic                    adaptive_eq_select_o,
   output var  logic                    eq_center_high_o,
   output var  logic                    aux_bridge_on_o,
   output var  logic                    source_hotplug_out_o,
   output var  logic                    power_down_on_o,
   output var  logic                    retimer_on_o
);

   if (SWING_W < 1 || EQ_LEVEL_W < 1)
   begin : g_check
      $error("mcr_misc_control: field widths must be at least one bit");
   end

   // Register reset value, so single reset bits can be picked out of it
   localparam logic [7:0] MISC_RESET = `MCR_MISC_CONTROL_RESET;

   logic [7:0]                 misc_control;
   logic                       commit_pending;
   logic [`MCR_PIN_COUNT-1:0]  pin_raw;
   logic [`MCR_PIN_COUNT-1:0]  pin_sync;

   wire                        cfg_sel;
   wire                        hotplug_in;
   wire                        out_en;
   wire                        power_down;
   wire                        apply_now;
   wire                        next_adaptive;
   wire [7:0]                  next_misc_control;
   wire                        next_retimer;
   mcr_lane_mode_t             lane_mode;

   assign pin_raw[`MCR_PIN_CFG_SEL] = host_cfg_sel_i;
   assign pin_raw[`MCR_PIN_HOTPLUG] = sink_hotplug_in_i;
   assign pin_raw[`MCR_PIN_OUT_EN]  = output_enable_i;

   // Pin synchronisers
   for (genvar g = 0; g < `MCR_PIN_COUNT; g++)
   begin : g_sync
      mcr_pin_sync #(
         .RESET_VAL (1'b0)
      ) u_sync (
         .clk_i     (clk_i),
         .reset_n_i (reset_n_i),
         .pin_i     (pin_raw[g]),
         .level_o   (pin_sync[g])
      );
   end

   assign cfg_sel    = pin_sync[`MCR_PIN_CFG_SEL];
   assign hotplug_in = pin_sync[`MCR_PIN_HOTPLUG];
   assign out_en     = pin_sync[`MCR_PIN_OUT_EN];

   // Power down while output enable or sink hot-plug is low
   assign power_down = !out_en || !hotplug_in;

   // Adaptive select keeps its value unless host configuration is selected
   assign next_adaptive = cfg_sel ? reg_wdata_i[`MCR_BIT_ADAPTIVE_EQ]
                                  : misc_control[`MCR_BIT_ADAPTIVE_EQ];

   // Commit bit is never stored, so it reads as zero
   assign next_misc_control = {reg_wdata_i[7:6], next_adaptive, reg_wdata_i[4:3],
                               1'b0, reg_wdata_i[1:0]};

   // Staged values reach the lanes on commit or during power down
   assign apply_now = commit_pending || power_down;

   assign lane_mode = mcr_lane_mode_t'(misc_control[`MCR_FUNC_HI:`MCR_FUNC_LO]);

   function automatic logic retimer_for(mcr_lane_mode_t mode, logic above, logic hirate);
      logic r;
      r = 1'b0;
      unique case (mode)
         MCR_MODE_REDRIVER:       r = 1'b0;
         MCR_MODE_AUTO_CROSSOVER: r = above;
         MCR_MODE_AUTO_HIRATE:    r = above || hirate;
         MCR_MODE_RETIMER:        r = 1'b1;
      endcase
      return r;
   endfunction

   assign next_retimer = retimer_for(lane_mode, rate_above_crossover_i, clock_ratio_flag_i);

   // Register and commit strobe
   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         misc_control   <= `MCR_MISC_CONTROL_RESET;
         commit_pending <= 1'b0;
      end
      else
      begin
         commit_pending <= reg_wr_i && reg_wdata_i[`MCR_BIT_COMMIT];
         if (reg_wr_i)
         begin
            misc_control <= next_misc_control;
         end
      end
   end

   // Applied lane settings
   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         lane_slew_o          <= '0;
         lane_term_o          <= '0;
         lane_deemph_o        <= '0;
         lane_swing_o         <= '0;
         lane_eq_level_o      <= '0;
         rx_equalizer_on_o    <= MISC_RESET[`MCR_BIT_RX_EQ_ON];
         adaptive_eq_select_o <= MISC_RESET[`MCR_BIT_ADAPTIVE_EQ];
      end
      else if (apply_now)
      begin
         lane_slew_o          <= staged_slew_i;
         lane_term_o          <= staged_term_i;
         lane_deemph_o        <= staged_deemph_i;
         lane_swing_o         <= staged_swing_i;
         lane_eq_level_o      <= staged_eq_level_i;
         rx_equalizer_on_o    <= misc_control[`MCR_BIT_RX_EQ_ON];
         adaptive_eq_select_o <= misc_control[`MCR_BIT_ADAPTIVE_EQ];
      end
   end

   // Direct controls and status
   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         reg_rdata_o          <= `MCR_MISC_CONTROL_RESET;
         eq_center_high_o     <= MISC_RESET[`MCR_BIT_PLACEMENT];
         aux_bridge_on_o      <= MISC_RESET[`MCR_BIT_AUX_BRIDGE];
         source_hotplug_out_o <= 1'b0;
         power_down_on_o      <= 1'b1;
         retimer_on_o         <= 1'b0;
      end
      else
      begin
         reg_rdata_o          <= misc_control & `MCR_COMMIT_READ_MASK;
         eq_center_high_o     <= misc_control[`MCR_BIT_PLACEMENT];
         aux_bridge_on_o      <= misc_control[`MCR_BIT_AUX_BRIDGE];
         source_hotplug_out_o <= hotplug_in &&
                                 !misc_control[`MCR_BIT_HOTPLUG_GATE];
         power_down_on_o      <= power_down;
         retimer_on_o         <= next_retimer;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   property p_commit_zero;
      reg_rdata_o[`MCR_BIT_COMMIT] == 1'b0;
   endproperty
   a_commit_zero: assert property (p_commit_zero)
      else $error("commit bit read back as one");

   property p_adaptive_locked;
      reg_wr_i && !cfg_sel |=> $stable(misc_control[`MCR_BIT_ADAPTIVE_EQ]);
   endproperty
   a_adaptive_locked: assert property (p_adaptive_locked)
      else $error("adaptive select changed while host config not selected");

   property p_commit_applies;
      reg_wr_i && reg_wdata_i[`MCR_BIT_COMMIT] |=> ##1
         (lane_slew_o == $past(staged_slew_i) && lane_swing_o == $past(staged_swing_i));
   endproperty
   a_commit_applies: assert property (p_commit_applies)
      else $error("commit did not apply staged lane settings");

   property p_staged_hold;
      !commit_pending && !power_down |=> $stable(lane_slew_o) && $stable(lane_term_o)
         && $stable(lane_eq_level_o) && $stable(rx_equalizer_on_o);
   endproperty
   a_staged_hold: assert property (p_staged_hold)
      else $error("lane settings changed without commit");

   property p_power_down_follow;
      power_down |=> lane_term_o == $past(staged_term_i);
   endproperty
   a_power_down_follow: assert property (p_power_down_follow)
      else $error("lane settings not tracking during power down");

   property p_hotplug_gate;
      misc_control[`MCR_BIT_HOTPLUG_GATE] |=> !source_hotplug_out_o;
   endproperty
   a_hotplug_gate: assert property (p_hotplug_gate)
      else $error("hot-plug forwarded while gated");

   property p_hotplug_pass;
      !misc_control[`MCR_BIT_HOTPLUG_GATE] |=> source_hotplug_out_o == $past(hotplug_in);
   endproperty
   a_hotplug_pass: assert property (p_hotplug_pass)
      else $error("hot-plug not forwarded while ungated");

   property p_mode_redriver;
      lane_mode == MCR_MODE_REDRIVER |=> !retimer_on_o;
   endproperty
   a_mode_redriver: assert property (p_mode_redriver)
      else $error("retimer on in redriver mode");

   property p_mode_cross;
      lane_mode == MCR_MODE_AUTO_CROSSOVER |=> retimer_on_o == $past(rate_above_crossover_i);
   endproperty
   a_mode_cross: assert property (p_mode_cross)
      else $error("crossover mode does not follow rate");

   property p_mode_hirate;
      lane_mode == MCR_MODE_AUTO_HIRATE && clock_ratio_flag_i |=> retimer_on_o;
   endproperty
   a_mode_hirate: assert property (p_mode_hirate)
      else $error("high-rate mode not retiming");

   property p_mode_retimer;
      lane_mode == MCR_MODE_RETIMER |=> retimer_on_o;
   endproperty
   a_mode_retimer: assert property (p_mode_retimer)
      else $error("retimer mode not retiming");

   property p_placement;
      reg_wr_i |=> ##1 eq_center_high_o == $past(reg_wdata_i[`MCR_BIT_PLACEMENT], 2);
   endproperty
   a_placement: assert property (p_placement)
      else $error("placement output does not follow write");

   property p_aux;
      reg_wr_i |=> ##1 aux_bridge_on_o == $past(reg_wdata_i[`MCR_BIT_AUX_BRIDGE], 2);
   endproperty
   a_aux: assert property (p_aux)
      else $error("aux bridge output does not follow write");

   property p_cov_commit;
      reg_wr_i && reg_wdata_i[`MCR_BIT_COMMIT] && !power_down;
   endproperty
   c_cov_commit: cover property (p_cov_commit);

   property p_cov_locked;
      reg_wr_i && !cfg_sel;
   endproperty
   c_cov_locked: cover property (p_cov_locked);

   property p_cov_power_down;
      !power_down ##1 power_down;
   endproperty
   c_cov_power_down: cover property (p_cov_power_down);

endmodule

`default_nettype wire

// >>> rtl/mcr_params.svh
/*
 * Offsets, field positions, reset values and widths for the
 * miscellaneous control register block.
 * Assumes it is included by its bare name from the package and the modules.
 */
`ifndef MCR_PARAMS_SVH
`define MCR_PARAMS_SVH

`define MCR_MISC_CONTROL_RESET    8'h39
`define MCR_BIT_PLACEMENT         7
`define MCR_BIT_HOTPLUG_GATE      6
`define MCR_BIT_ADAPTIVE_EQ       5
`define MCR_BIT_RX_EQ_ON          4
`define MCR_BIT_AUX_BRIDGE        3
`define MCR_BIT_COMMIT            2
`define MCR_FUNC_HI               1
`define MCR_FUNC_LO               0
`define MCR_COMMIT_READ_MASK      8'hFB
`define MCR_SLEW_W                2
`define MCR_TERM_W                2
`define MCR_DEEMPH_W              2
`define MCR_SWING_W               6
`define MCR_EQ_LEVEL_W            4
`define MCR_SYNC_STAGES           3
`define MCR_PIN_COUNT             3
`define MCR_PIN_CFG_SEL           0
`define MCR_PIN_HOTPLUG           1
`define MCR_PIN_OUT_EN            2

`endif

// >>> rtl/mcr_pin_sync.sv
/*
 * Three-stage synchroniser for one pin; the output changes once the
 * second and third stages agree.
 * Assumes clk_i is the block clock and reset_n_i a synchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mcr_params.svh"

module mcr_pin_sync
#(
   parameter logic RESET_VAL = 1'b0
)
(
   input  wire logic clk_i,
   input  wire logic reset_n_i,
   input  wire logic pin_i,
   output var  logic level_o
);

   logic [`MCR_SYNC_STAGES-1:0] stage;
   wire                         agree;

   assign agree = (stage[1] == stage[2]);

   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         stage   <= {`MCR_SYNC_STAGES{RESET_VAL}};
         level_o <= RESET_VAL;
      end
      else
      begin
         stage <= {stage[1:0], pin_i};
         if (agree)
         begin
            level_o <= stage[2];
         end
      end
   end

endmodule

`default_nettype wire

// >>> rtl/mcr_pkg.sv
/*
 * Types shared by the miscellaneous control register block.
 * Assumes mcr_params.svh is on the include path.
 */
`include "mcr_params.svh"

package mcr_pkg;

   typedef enum logic [1:0]
   {
      MCR_MODE_REDRIVER,
      MCR_MODE_AUTO_CROSSOVER,
      MCR_MODE_AUTO_HIRATE,
      MCR_MODE_RETIMER
   } mcr_lane_mode_t;

endpackage
